//--- verilog/csbs_pkg.sv
package csbs_pkg;
	// port size encodings from the pin assignment field
	localparam logic [1:0] CSBS_PORT_8 = 2'h2;
	localparam logic [1:0] CSBS_PORT_16 = 2'h3;
	// lane select encodings
	localparam logic [1:0] CSBS_LANE_OFF = 2'h0;
	localparam logic [1:0] CSBS_LANE_LO = 2'h1;
	localparam logic [1:0] CSBS_LANE_HI = 2'h2;
	localparam logic [1:0] CSBS_LANE_ANY = 2'h3;
	// wait-state field special values
	localparam logic [3:0] CSBS_WAIT_FAST = 4'hE;
	localparam logic [3:0] CSBS_WAIT_EXT = 4'hF;
	// strobe select: address strobe or data strobe timing
	localparam logic CSBS_STROBE_SELECT_AS = 1'b0;
	// region kind: cpu space
	localparam logic [1:0] CSBS_REGION_CPU = 2'h0;
	localparam logic [2:0] CSBS_FC_CPU = 3'h7;
	localparam logic [3:0] CSBS_IACK_TYPE = 4'hF;
	localparam logic [2:0] CSBS_IPL_ANY = 3'h0;
	// xfer_width codes
	localparam logic [1:0] CSBS_SIZ_BYTE = 2'h1;
	// rw option: 1 = read only, 2 = write only, 3 = both
	localparam logic [1:0] CSBS_RW_READ = 2'h1;
	localparam logic [1:0] CSBS_RW_WRITE = 2'h2;
	// base field compares ADDR[23:11]
	localparam int CSBS_BASE_LSB = 11;
	localparam int CSBS_ADDR_W = 24;
	localparam int CSBS_BASE_W = 13;
	typedef enum logic [2:0] {
		CSBS_S_IDLE = 3'b000,
		CSBS_S_ADDR = 3'b001,
		CSBS_S_WAIT = 3'b010,
		CSBS_S_ACK = 3'b011,
		CSBS_S_END = 3'b100
	} csbs_state_e;
endpackage

//--- verilog/csbs_chip_select.sv
`timescale 1ns/1ps
// Function
// - after programmed waits assert size_ack_hi for 8-bit, size_ack_lo for 16-bit port
// - decode xfer_width to find which data byte lanes a transfer uses
// - on 16-bit ports qualify chip select with lane_select_field
// - lane 00 off, 01 lsb zero, 10 lsb one, 11 either byte
// - wait field 1110 runs a two-clock fast-termination transfer
// - fast cycles skip S2 and S3, acknowledge generated internally
// - fast cycles assert data_strobe on reads only, never on writes
// - fast read S0 presents address, func_code, xfer_width, read_write high
// - fast read S1 asserts both strobes; decode picks upper, lower or both lanes
// - fast read S5 negates strobes; address and controls stay valid
// - fast write S0 read_write low; S1 valid_strobe, decode includes valid_strobe
// - fast write S4 data valid, peripheral latches, acknowledge raised internally
// - fast write S5 negates valid_strobe; address, data, controls stay valid
// - interrupt acknowledge selects only when level matches, or field is 000
// - iack recognised by func_code 111, type 1111, other lines one
// - auto_vector or acknowledge only for external request-pin interrupts
// - each wait state one clock from S3; zero waits gives three clocks
// - wait field 1111 selects external termination, no internal acknowledge except auto_vector on an autovectored iack
module csbs_chip_select (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// bus master request
	input wire logic cycle_start_in,
	input wire logic [csbs_pkg::CSBS_ADDR_W-1:0] addr_in,
	input wire logic [2:0] func_code_in,
	input wire logic [1:0] xfer_width_in,
	input wire logic read_write_in,
	input wire logic irq_external_in,
	input wire logic ext_size_ack_in,
	// chip-select configuration
	input wire logic cs_enable_in,
	input wire logic [1:0] port_size_in,
	input wire logic [csbs_pkg::CSBS_BASE_W-1:0] base_field_in,
	input wire logic [1:0] region_kind_sel_in,
	input wire logic [1:0] rw_option_in,
	input wire logic [1:0] lane_select_field_in,
	input wire logic strobe_select_in,
	input wire logic [3:0] wait_field_in,
	input wire logic [2:0] irq_level_field_in,
	input wire logic auto_vector_en_in,
	// bus outputs
	output logic [csbs_pkg::CSBS_ADDR_W-1:0] bus_addr_out,
	output logic [2:0] bus_func_code_out,
	output logic [1:0] bus_xfer_width_out,
	output logic bus_read_write_out,
	output logic valid_strobe_out,
	output logic data_strobe_out,
	output logic chip_select_n_out,
	output logic lane_hi_out,
	output logic lane_lo_out,
	output logic size_ack_hi_out,
	output logic size_ack_lo_out,
	output logic auto_vector_out,
	output logic cycle_done_out
);
	import csbs_pkg::*;

	// ==========================================
	// request capture
	csbs_state_e state;
	logic [3:0] wait_cnt;
	logic is_fast;
	logic is_ext;
	logic sel;
	logic iack;
	logic lane_hi;
	logic lane_lo;
	logic next_sel;
	logic next_iack;
	logic next_lane_hi;
	logic next_lane_lo;
	logic lane_ok;
	logic rw_ok;
	logic space_ok;

	// ==========================================
	// match decode
	always_comb begin
		// byte accesses use one lane, wider ones both
		if (xfer_width_in == CSBS_SIZ_BYTE) begin
			// lsb zero is the lower byte lane
			next_lane_hi = addr_in[0];
			next_lane_lo = ~addr_in[0];
		end else begin
			next_lane_hi = 1'b1;
			next_lane_lo = 1'b1;
		end
		// lsb qualification only on 16-bit ports; field 00 disables select on every port
		case (lane_select_field_in)
			CSBS_LANE_OFF: lane_ok = 1'b0;
			CSBS_LANE_LO: lane_ok = (port_size_in != CSBS_PORT_16) | ~addr_in[0];
			CSBS_LANE_HI: lane_ok = (port_size_in != CSBS_PORT_16) | addr_in[0];
			default: lane_ok = 1'b1;
		endcase
		// iack decode
		next_iack = (func_code_in == CSBS_FC_CPU) && (addr_in[19:16] == CSBS_IACK_TYPE)
			&& (&addr_in[CSBS_ADDR_W-1:20]) && (&addr_in[15:4]) && addr_in[0];
		if (read_write_in) begin
			rw_ok = rw_option_in[0];
		end else begin
			rw_ok = rw_option_in[1];
		end
		space_ok = (region_kind_sel_in == CSBS_REGION_CPU) == (func_code_in == CSBS_FC_CPU);
		// level match, zero matches any level
		if (next_iack) begin
			space_ok = space_ok && irq_external_in && ((irq_level_field_in == CSBS_IPL_ANY)
				|| (irq_level_field_in == addr_in[3:1]));
		end
		next_sel = cs_enable_in && lane_ok && rw_ok && space_ok
			&& (addr_in[CSBS_ADDR_W-1:CSBS_BASE_LSB] == base_field_in);
	end

	assign is_fast = (wait_field_in == CSBS_WAIT_FAST) || (iack && auto_vector_en_in);
	assign is_ext = (wait_field_in == CSBS_WAIT_EXT) && !(iack && auto_vector_en_in);

	// ==========================================
	// bus state sequence: S0 addr, S1 strobes, S2-S3 and waits, S4 ack, S5 end
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= CSBS_S_IDLE;
			wait_cnt <= 4'h0;
		end else begin
			case (state)
				CSBS_S_IDLE: begin
					if (cycle_start_in) begin
						state <= CSBS_S_ADDR;
					end
				end
				CSBS_S_ADDR: begin
					wait_cnt <= wait_field_in;
					// fast cycles drop S2 and S3
					if (sel && is_fast) begin
						state <= CSBS_S_ACK;
					end else begin
						state <= CSBS_S_WAIT;
					end
				end
				CSBS_S_WAIT: begin
					// one clock per wait state from S3
					if (ext_size_ack_in) begin
						state <= CSBS_S_ACK;
					end else if (sel && !is_ext && wait_cnt == 4'h0) begin
						state <= CSBS_S_ACK;
					end else if (wait_cnt != 4'h0) begin
						wait_cnt <= wait_cnt - 4'h1;
					end
				end
				CSBS_S_ACK: state <= CSBS_S_END;
				CSBS_S_END: state <= CSBS_S_IDLE;
				default: state <= CSBS_S_IDLE;
			endcase
		end
	end

	// ==========================================
	// address phase hold; stays valid through S5
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			bus_addr_out <= '0;
			bus_func_code_out <= 3'h0;
			bus_xfer_width_out <= 2'h0;
			bus_read_write_out <= 1'b1;
			sel <= 1'b0;
			iack <= 1'b0;
			lane_hi <= 1'b0;
			lane_lo <= 1'b0;
		end else if (state == CSBS_S_IDLE && cycle_start_in) begin
			// read_write low on writes
			bus_addr_out <= addr_in;
			bus_func_code_out <= func_code_in;
			bus_xfer_width_out <= xfer_width_in;
			bus_read_write_out <= read_write_in;
			sel <= next_sel;
			iack <= next_iack;
			lane_hi <= next_lane_hi;
			lane_lo <= next_lane_lo;
		end
	end

	// ==========================================
	// strobes
	logic in_strobe;
	assign in_strobe = (state == CSBS_S_ADDR) || (state == CSBS_S_WAIT) || (state == CSBS_S_ACK);
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			valid_strobe_out <= 1'b0;
			data_strobe_out <= 1'b0;
		end else begin
			// asserted S1..S4, negated in S5
			valid_strobe_out <= (state == CSBS_S_IDLE && cycle_start_in)
				|| (in_strobe && state != CSBS_S_ACK);
			// data strobe on reads only
			// start term uses the live request, the held copy is still the old cycle's
			data_strobe_out <= (state == CSBS_S_IDLE && cycle_start_in && read_write_in)
				|| (bus_read_write_out && in_strobe && state != CSBS_S_ACK);
		end
	end

	// chip select timed to chosen strobe; writes only with address strobe
	// decode includes valid_strobe on writes
	assign chip_select_n_out = !(sel && (strobe_select_in == CSBS_STROBE_SELECT_AS ? valid_strobe_out
		: data_strobe_out));
	assign lane_hi_out = sel && lane_hi && valid_strobe_out;
	assign lane_lo_out = sel && lane_lo && valid_strobe_out;

	// ==========================================
	// internal acknowledge in S4
	logic int_ack;
	assign int_ack = (state == CSBS_S_ACK) && sel && !is_ext;
	assign size_ack_hi_out = int_ack && !(iack && auto_vector_en_in)
		&& (port_size_in == CSBS_PORT_8);
	assign size_ack_lo_out = int_ack && !(iack && auto_vector_en_in)
		&& (port_size_in == CSBS_PORT_16);
	assign auto_vector_out = int_ack && iack && auto_vector_en_in;
	assign cycle_done_out = (state == CSBS_S_END);

	// ==========================================
	// checks
	sequence s_fast_start;
		state == CSBS_S_ADDR && sel && is_fast;
	endsequence
	property p_fast_two;
		@(posedge clk_in) disable iff (!reset_n_in)
		s_fast_start |=> state == CSBS_S_ACK ##1 state == CSBS_S_END;
	endproperty
	a_fast_two: assert property (p_fast_two) else $error("fast cycle not two states");
	property p_no_ds_write;
		@(posedge clk_in) disable iff (!reset_n_in)
		state == CSBS_S_ACK && !bus_read_write_out |-> !data_strobe_out;
	endproperty
	a_no_ds_write: assert property (p_no_ds_write) else $error("ds on write");
	property p_s5_neg;
		@(posedge clk_in) disable iff (!reset_n_in)
		state == CSBS_S_END |-> !valid_strobe_out && !data_strobe_out;
	endproperty
	a_s5_neg: assert property (p_s5_neg) else $error("strobes in S5");
	property p_ext_noack;
		@(posedge clk_in) disable iff (!reset_n_in)
		is_ext |-> !size_ack_hi_out && !size_ack_lo_out;
	endproperty
	a_ext_noack: assert property (p_ext_noack) else $error("ack on external");
	property p_port_ack;
		@(posedge clk_in) disable iff (!reset_n_in)
		size_ack_lo_out |-> port_size_in == CSBS_PORT_16 && !size_ack_hi_out;
	endproperty
	a_port_ack: assert property (p_port_ack) else $error("wrong size ack");
	property p_zero_wait;
		@(posedge clk_in) disable iff (!reset_n_in)
		state == CSBS_S_ADDR && sel && wait_field_in == 4'h0 |=> ##1 state == CSBS_S_ACK;
	endproperty
	a_zero_wait: assert property (p_zero_wait) else $error("zero wait timing");
	property p_hold_s5;
		@(posedge clk_in) disable iff (!reset_n_in)
		state == CSBS_S_END |-> $stable(bus_addr_out) && $stable(bus_read_write_out);
	endproperty
	a_hold_s5: assert property (p_hold_s5) else $error("address moved in S5");
	property p_auto_vector_ext;
		@(posedge clk_in) disable iff (!reset_n_in)
		auto_vector_out |-> iack && sel;
	endproperty
	a_auto_vector_ext: assert property (p_auto_vector_ext) else $error("auto_vector without iack");

	// ==========================================
	// strobe checks per direction, fast cycle end and ack pulse width
	sequence s_read_s1;
		state == CSBS_S_ADDR && bus_read_write_out;
	endsequence
	sequence s_write_s1;
		state == CSBS_S_ADDR && !bus_read_write_out;
	endsequence
	property p_read_s1;
		@(posedge clk_in) disable iff (!reset_n_in)
		s_read_s1 |-> valid_strobe_out && data_strobe_out;
	endproperty
	a_read_s1: assert property (p_read_s1) else $error("read strobes missing in S1");
	property p_write_s1;
		@(posedge clk_in) disable iff (!reset_n_in)
		s_write_s1 |-> valid_strobe_out && !data_strobe_out;
	endproperty
	a_write_s1: assert property (p_write_s1) else $error("write strobes wrong in S1");
	property p_fast_done;
		@(posedge clk_in) disable iff (!reset_n_in)
		s_fast_start |-> ##2 cycle_done_out;
	endproperty
	a_fast_done: assert property (p_fast_done) else $error("fast cycle end late");
	property p_ack_pulse;
		@(posedge clk_in) disable iff (!reset_n_in)
		size_ack_hi_out || size_ack_lo_out || auto_vector_out
			|=> !size_ack_hi_out && !size_ack_lo_out && !auto_vector_out;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

	// ==========================================
	// lane and level checks
	property p_byte_lane;
		@(posedge clk_in) disable iff (!reset_n_in)
		valid_strobe_out && sel && bus_xfer_width_out == CSBS_SIZ_BYTE
			|-> lane_hi_out != lane_lo_out;
	endproperty
	a_byte_lane: assert property (p_byte_lane) else $error("byte access lanes wrong");
	property p_lane_lo;
		@(posedge clk_in) disable iff (!reset_n_in)
		state == CSBS_S_ADDR && sel && port_size_in == CSBS_PORT_16
			&& lane_select_field_in == CSBS_LANE_LO |-> !bus_addr_out[0];
	endproperty
	a_lane_lo: assert property (p_lane_lo) else $error("lower lane select on odd byte");
	property p_lane_off;
		@(posedge clk_in) disable iff (!reset_n_in)
		state == CSBS_S_ADDR && lane_select_field_in == CSBS_LANE_OFF |-> chip_select_n_out;
	endproperty
	a_lane_off: assert property (p_lane_off) else $error("disabled select asserted");
	property p_iack_level;
		@(posedge clk_in) disable iff (!reset_n_in)
		state == CSBS_S_ADDR && sel && iack && irq_level_field_in != CSBS_IPL_ANY
			|-> bus_addr_out[3:1] == irq_level_field_in;
	endproperty
	a_iack_level: assert property (p_iack_level) else $error("iack level mismatch");
	property p_iack_ext;
		@(posedge clk_in) disable iff (!reset_n_in)
		state == CSBS_S_ADDR && sel && iack |-> irq_external_in;
	endproperty
	a_iack_ext: assert property (p_iack_ext) else $error("iack select for internal irq");

	// ==========================================
	// wait length check
	// counts wait clocks so the check does not need a long repetition
	logic [4:0] wait_seen;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wait_seen <= 5'h0;
		end else if (state == CSBS_S_ADDR) begin
			wait_seen <= 5'h0;
		end else if (state == CSBS_S_WAIT) begin
			wait_seen <= wait_seen + 5'h1;
		end
	end
	property p_wait_len;
		@(posedge clk_in) disable iff (!reset_n_in)
		state == CSBS_S_WAIT && sel && !is_ext && wait_cnt == 4'h0 && !ext_size_ack_in
			|-> wait_seen == {1'b0, wait_field_in};
	endproperty
	a_wait_len: assert property (p_wait_len) else $error("wait count wrong");
endmodule

//--- tb/csbs_ext_device.sv
`timescale 1ns/1ps
module csbs_ext_device (
	// clock and reset
	input wire logic clk_in,
	input wire logic reset_n_in,
	// bus side
	input wire logic valid_strobe_in,
	input wire logic respond_in,
	input wire logic [3:0] delay_in,
	// acknowledge back
	output logic ext_size_ack_out
);
	logic [3:0] cnt;
	// ==========================================
	// handshake
	// ack dropped at the first edge after strobe negates, never held into next cycle
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt <= 4'h0;
			ext_size_ack_out <= 1'b0;
		end else if (!valid_strobe_in) begin
			cnt <= 4'h0;
			ext_size_ack_out <= 1'b0;
		end else begin
			cnt <= cnt + 4'h1;
			ext_size_ack_out <= respond_in && (cnt >= delay_in);
		end
	end
endmodule

//--- tb/chip_select_bus_sizing_iack_bench.sv
`timescale 1ns/1ps
module chip_select_bus_sizing_iack_bench;
	import csbs_pkg::*;
	localparam logic [23:0] NA = 24'h091810;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic start, rw, irq_ext, ext_ack, strobe_select, av_en, resp;
	logic cs_n, lane_hi, lane_lo, ack_hi, ack_lo, avo, done, vs, ds, brw;
	logic c1_cs, c1_ds, c1_vs, c1_hi, c1_lo, end_rw, end_vs, e;
	logic [23:0] addr;
	logic [12:0] base;
	logic [2:0] fc, lvl, ack_bits;
	logic [1:0] width, psize, region, rwo, lane;
	logic [3:0] wf, dly;
	int ack_cyc, done_cyc, error_cnt, samples_checked, cyc;
	// ==========================================
	// instances
	csbs_chip_select csbs_chip_select_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.cycle_start_in(start), .addr_in(addr), .func_code_in(fc), .xfer_width_in(width),
		.read_write_in(rw), .irq_external_in(irq_ext), .ext_size_ack_in(ext_ack),
		.cs_enable_in(1'b1), .port_size_in(psize), .base_field_in(base),
		.region_kind_sel_in(region), .rw_option_in(rwo), .lane_select_field_in(lane),
		.strobe_select_in(strobe_select), .wait_field_in(wf), .irq_level_field_in(lvl),
		.auto_vector_en_in(av_en), .bus_addr_out(), .bus_func_code_out(),
		.bus_xfer_width_out(), .bus_read_write_out(brw), .valid_strobe_out(vs),
		.data_strobe_out(ds), .chip_select_n_out(cs_n), .lane_hi_out(lane_hi),
		.lane_lo_out(lane_lo), .size_ack_hi_out(ack_hi), .size_ack_lo_out(ack_lo),
		.auto_vector_out(avo), .cycle_done_out(done));
	csbs_ext_device csbs_ext_device_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.valid_strobe_in(vs), .respond_in(resp), .delay_in(dly), .ext_size_ack_out(ext_ack));
	always #50 clk_in = ~clk_in;
	// ==========================================
	// helpers
	task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
		samples_checked++;
		if (g !== x) begin
			error_cnt++;
			$display("[FAIL] %s expected %0h seen %0h", n, x, g);
		end
	endtask
	task summarize;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			summarize;
		end
	end
	task cfg(input logic [1:0] p, input logic [3:0] w, input logic [1:0] l);
		psize = p;
		wf = w;
		lane = l;
	endtask
	// one extra edge after done so the next start lands in idle
	task automatic run(input logic r, input logic [23:0] a, input logic [2:0] f,
		input logic [1:0] w);
		rw = r;
		addr = a;
		fc = f;
		width = w;
		start = 1'b1;
		ack_cyc = 0;
		done_cyc = 0;
		ack_bits = 3'h0;
		@(posedge clk_in);
		#10;
		start = 1'b0;
		for (int k = 1; k < 40 && done_cyc == 0; k++) begin
			if (k == 1) begin
				{c1_cs, c1_ds, c1_vs, c1_hi, c1_lo} = {cs_n, ds, vs, lane_hi, lane_lo};
			end
			if (ack_cyc == 0 && (ack_hi || ack_lo || avo)) begin
				ack_cyc = k;
			end
			ack_bits = ack_bits | {ack_hi, ack_lo, avo};
			if (done === 1'b1) begin
				done_cyc = k;
				end_rw = brw;
				end_vs = vs;
			end
			@(posedge clk_in);
			#10;
		end
	endtask
	// ==========================================
	// scenarios
	task t_fast;
		cfg(CSBS_PORT_16, CSBS_WAIT_FAST, CSBS_LANE_ANY);
		run(1'b1, NA, 3'h5, 2'h2);
		chk("rd cs", 8'h00, c1_cs);
		chk("rd ds", 8'h01, c1_ds);
		chk("rd vs", 8'h01, c1_vs);
		chk("rd lanes", 8'h03, {c1_hi, c1_lo});
		chk("rd ack cycle", 8'h02, 8'(ack_cyc));
		chk("rd ack", 8'h02, ack_bits);
		chk("rd done", 8'h03, 8'(done_cyc));
		chk("rd rw end", 8'h01, end_rw);
		chk("rd vs end", 8'h00, end_vs);
		cfg(CSBS_PORT_8, CSBS_WAIT_FAST, CSBS_LANE_ANY);
		run(1'b0, NA + 24'h1, 3'h5, CSBS_SIZ_BYTE);
		chk("wr cs", 8'h00, c1_cs);
		chk("wr ds", 8'h00, c1_ds);
		chk("wr vs", 8'h01, c1_vs);
		chk("wr ack cycle", 8'h02, 8'(ack_cyc));
		chk("wr ack", 8'h04, ack_bits);
		chk("wr done", 8'h03, 8'(done_cyc));
		chk("wr rw end", 8'h00, end_rw);
		run(1'b1, NA, 3'h5, 2'h2);
		chk("rd after wr ds", 8'h01, c1_ds);
	endtask
	task t_waits;
		cfg(CSBS_PORT_16, 4'h0, CSBS_LANE_ANY);
		for (int n = 0; n < 4; n += 3) begin
			wf = 4'(n);
			run(1'b1, NA, 3'h5, 2'h2);
			chk("wait ack", 8'(3 + n), 8'(ack_cyc));
			chk("wait done", 8'(4 + n), 8'(done_cyc));
		end
		wf = CSBS_WAIT_EXT;
		resp = 1'b1;
		dly = 4'h4;
		run(1'b1, NA, 3'h5, 2'h2);
		chk("ext no internal ack", 8'h00, ack_bits);
		chk("ext done", 8'h08, 8'(done_cyc));
	endtask
	task t_lanes;
		dly = 4'h0;
		for (int f = 0; f < 4; f++) begin
			for (int b = 0; b < 2; b++) begin
				cfg(CSBS_PORT_16, CSBS_WAIT_FAST, 2'(f));
				e = (f == 3) || (f == 1 && b == 0) || (f == 2 && b == 1);
				run(1'b1, NA + 24'(b), 3'h5, CSBS_SIZ_BYTE);
				chk("lane cs", 8'(!e), c1_cs);
				if (e) chk("lane bits", 8'(1 << b), {c1_hi, c1_lo});
			end
		end
	endtask
	task automatic iack(input logic [2:0] f, input logic [2:0] l, input logic x, input logic v);
		lvl = f;
		irq_ext = x;
		av_en = v;
		run(1'b1, 24'hFFFFF1 | {20'h0, l, 1'b0}, CSBS_FC_CPU, CSBS_SIZ_BYTE);
	endtask
	task t_iack;
		base = 13'h1FFF;
		region = CSBS_REGION_CPU;
		rwo = CSBS_RW_READ;
		cfg(CSBS_PORT_16, CSBS_WAIT_FAST, CSBS_LANE_ANY);
		iack(3'h3, 3'h3, 1'b1, 1'b0);
		chk("iack match", 8'h00, c1_cs);
		iack(3'h3, 3'h5, 1'b1, 1'b0);
		chk("iack other level", 8'h01, c1_cs);
		iack(3'h0, 3'h6, 1'b1, 1'b0);
		chk("iack any level", 8'h00, c1_cs);
		iack(3'h0, 3'h2, 1'b1, 1'b1);
		chk("autovector", 8'h01, ack_bits[0]);
		chk("autovector cycle", 8'h02, 8'(ack_cyc));
		iack(3'h0, 3'h2, 1'b0, 1'b1);
		chk("internal irq", 8'h00, ack_bits[0]);
	endtask
	// ==========================================
	// main sequence
	initial begin
		{start, rw, irq_ext, av_en, resp} = 5'h0;
		strobe_select = CSBS_STROBE_SELECT_AS;
		base = 13'h0123; // iack select kept apart
		region = 2'h3;
		rwo = 2'h3;
		{addr, fc, width, lvl, dly} = 36'h0;
		cfg(CSBS_PORT_16, CSBS_WAIT_FAST, CSBS_LANE_ANY);
		repeat (16) @(posedge clk_in);
		#10;
		reset_n_in = 1'b1;
		t_fast();
		t_waits();
		t_lanes();
		t_iack();
		summarize;
	end
endmodule
